// *** verilog/mtw_walker.sv ***
// Table walker and fault unit: walks tables, checks access, reports aborts
// How it works
// [RULE1] Level one type: invalid, coarse, section, fine
// [RULE2] C and B bits classify the region
// [RULE3] Bits 8:5 pick one of sixteen domains
// [RULE4] Section permission field is bits 11:10
// [RULE5] Section address takes descriptor bits 31:20
// [RULE6] Coarse descriptor starts level two fetch
// [RULE7] Fine descriptor starts level two fetch
// [RULE8] Level two type: invalid, large, small, tiny
// [RULE9] Page address bits come from level two
// [RULE10] Coarse table: 256 entries, small or large
// [RULE11] Fine table: 1024 entries, any page size
// [RULE12] Table builder replicates large and small entries
// [RULE13] Unequal sub-page fields load one quarter
// [RULE14] Tiny pages have one permission field
// [RULE15] Section permission checked before address given
// [RULE16] Alignment check enabled by its own bit
// [RULE17] Translation faults only with translation enabled
// [RULE18] Fault aborts access, suppresses external access
// [RULE19] Fault code and domain recorded per kind
// [RULE20] Data aborts latch address, prefetches do not
// [RULE21] Only highest priority fault is reported
// [RULE22] No-access or reserved domain raises fault
// [RULE23] Client domain checks permission field
// [RULE24] Alignment code written, domain left invalid
// [RULE25] Level two index from virtual address bits
// [RULE26] Sub-page field picked by address bits
module mtw_walker
  import mtw_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // Control bits
  input  wire logic        CTRL_MMU_EN,
  input  wire logic        CTRL_ALIGN_EN,
  input  wire logic        CTRL_S,
  input  wire logic        CTRL_R,
  input  wire logic [17:0] TTB_BASE,
  input  wire logic [31:0] DOMAIN_ACCESS,
  // Core request
  input  wire logic        REQ_VALID,
  input  wire mtw_req_t    REQ,
  output logic             REQ_READY,
  // Core response
  output logic             RESP_VALID,
  output logic             RESP_ABORT,
  output logic [31:0]      RESP_PA,
  output mtw_class_t       RESP_CLASS,
  output logic             EXT_GO,
  // Table memory read port
  output logic             MEM_RD_REQ,
  output logic [31:0]      MEM_RD_ADDR,
  input  wire logic        MEM_RD_ACK,
  input  wire logic [31:0] MEM_RD_DATA,
  // TLB fill
  output logic             TLB_WR,
  output mtw_tlb_t         TLB_FILL,
  // Fault records
  output mtw_fstat_t       DATA_FAULT_STATUS,
  output mtw_fstat_t       PREF_FAULT_STATUS,
  output logic [31:0]      FAULT_ADDRESS
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Mask of the bits below a boundary
  function automatic logic [31:0] low_mask(input logic [4:0] lsb);
    return (32'h1 << lsb) - 32'h1;
  endfunction

  // Upper bits from a base, lower bits from the virtual address
  function automatic logic [31:0] merge(input logic [31:0] hi, input logic [31:0] lo,
                                        input logic [4:0] lsb);
    return (hi & ~low_mask(lsb)) | (lo & low_mask(lsb));
  endfunction

  // Boundary of a mapping size
  function automatic logic [4:0] size_lsb(input mtw_size_t sz);
    case (sz)
      SZ_1M:   return 5'(SEC_BASE_LSB);
      SZ_64K:  return 5'(LARGE_LSB);
      SZ_16K:  return 5'(QLARGE_LSB);
      SZ_4K:   return 5'(SMALL_LSB);
      default: return 5'(TINY_LSB);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  mtw_state_t  state_r;
  mtw_state_t  state_nxt;
  mtw_req_t    req_r;
  logic [31:0] desc1_r;
  logic [31:0] desc2_r;

  logic        take;
  logic        ack;
  logic        align_bad;
  logic [1:0]  t1_in;
  logic [31:0] l1_addr;
  logic [31:0] l2_addr;

  // Request handshake and table read answer
  assign take    = REQ_VALID && REQ_READY;
  assign ack     = MEM_RD_ACK && MEM_RD_REQ;
  assign t1_in   = MEM_RD_DATA[TYPE_MSB:0];
  assign l1_addr = {TTB_BASE, REQ.va[AMSB:SEC_BASE_LSB], WORD_OFS};

  // Misaligned data word or halfword, independent of translation
  always_comb
  begin
    align_bad = CTRL_ALIGN_EN && !REQ.instr &&                        // see [RULE16]
                ((REQ.asz == AS_WORD && REQ.va[TYPE_MSB:0] != WORD_OFS) ||
                 (REQ.asz == AS_HALF && REQ.va[0]));
  end

  // Level two entry address: coarse 256 entries, fine 1024 entries
  always_comb
  begin
    if (t1_in == L1_COARSE)
      l2_addr = {MEM_RD_DATA[AMSB:COARSE_LSB],                         // see [RULE6]
                 req_r.va[SEC_BASE_LSB-1:COARSE_IDX], WORD_OFS};       // see [RULE10] [RULE25]
    else
      l2_addr = {MEM_RD_DATA[AMSB:FINE_LSB],                           // see [RULE7]
                 req_r.va[SEC_BASE_LSB-1:FINE_IDX], WORD_OFS};         // see [RULE11] [RULE25]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor check

  logic        is_sec;
  logic [1:0]  t1;
  logic [1:0]  t2;
  logic [3:0]  dom;
  logic [1:0]  dacc;
  logic [1:0]  sub;
  logic        perm_same;
  logic [1:0]  perm_sel;
  logic        perm_ok;
  logic        page_bad;
  logic [31:0] map_desc;
  mtw_size_t   map_size;
  logic [4:0]  map_lsb;

  always_comb
  begin
    t1        = desc1_r[TYPE_MSB:0];
    t2        = desc2_r[TYPE_MSB:0];
    is_sec    = (t1 == L1_SECTION);
    dom       = desc1_r[DOM_LSB +: DOM_W];                             // see [RULE3]
    dacc      = DOMAIN_ACCESS[{dom, 1'b0} +: 2];
    sub       = (t2 == L2_SMALL) ? req_r.va[TINY_LSB +: 2]              // see [RULE26]
                                 : req_r.va[QLARGE_LSB +: 2];
    perm_same = desc2_r[PERM0_LSB +: PERM_ALL_W] == {4{desc2_r[PERM0_LSB +: 2]}};
    map_desc  = is_sec ? desc1_r : desc2_r;
    // Coarse tables hold no tiny pages
    page_bad  = !is_sec && (t2 == L2_INVALID ||                        // see [RULE8]
                            (t1 == L1_COARSE && t2 == L2_TINY));        // see [RULE10]
    if (is_sec)
      perm_sel = desc1_r[SEC_PERM_LSB +: 2];                           // see [RULE4]
    else if (t2 == L2_TINY)
      perm_sel = desc2_r[PERM0_LSB +: 2];                              // see [RULE14]
    else
      perm_sel = desc2_r[PERM0_LSB + {sub, 1'b0} +: 2];                // see [RULE26]
    // Mapping size and address boundary
    if (is_sec)
    begin
      map_size = SZ_1M;
      map_lsb  = 5'(SEC_BASE_LSB);                                     // see [RULE5]
    end
    else if (t2 == L2_LARGE)
    begin
      map_size = perm_same ? SZ_64K : SZ_16K;                          // see [RULE13]
      map_lsb  = 5'(LARGE_LSB);                                        // see [RULE9]
    end
    else if (t2 == L2_SMALL)
    begin
      map_size = perm_same ? SZ_4K : SZ_1K;                            // see [RULE13]
      map_lsb  = 5'(SMALL_LSB);                                        // see [RULE9]
    end
    else
    begin
      map_size = SZ_1K;
      map_lsb  = 5'(TINY_LSB);                                         // see [RULE9]
    end
  end

  // Permission field verdict
  mtw_perm_check u_perm (
    .perm  (perm_sel),
    .sys_s (CTRL_S),
    .rom_r (CTRL_R),
    .priv  (req_r.priv),
    .write (req_r.write),
    .ok    (perm_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Finish decision and next state

  logic        fin;
  logic        fin_abort;
  logic        fin_fill;
  logic        fin_instr;
  logic [3:0]  fin_code;
  logic [3:0]  fin_dom;
  logic [31:0] fin_va;
  logic [31:0] fin_pa;
  mtw_class_t  fin_cls;

  always_comb
  begin
    state_nxt = state_r;
    fin       = 1'b0;
    fin_abort = 1'b0;
    fin_fill  = 1'b0;
    fin_instr = req_r.instr;
    fin_code  = FC_ALIGN;
    fin_dom   = DOM_INVALID;
    fin_va    = req_r.va;
    fin_pa    = merge(map_desc, req_r.va, map_lsb);
    fin_cls   = mtw_class_t'(map_desc[CB_LSB +: 2]);                   // see [RULE2]
    case (state_r)
      S_IDLE:
      begin
        fin_instr = REQ.instr;
        fin_va    = REQ.va;
        fin_pa    = REQ.va;
        fin_cls   = CL_NCNB;
        if (take && align_bad)
        begin
          fin       = 1'b1;                                            // see [RULE21]
          fin_abort = 1'b1;
          fin_code  = FC_ALIGN;                                        // see [RULE24]
        end
        else if (take && !CTRL_MMU_EN)
          fin = 1'b1;                                                  // see [RULE17]
        else if (take)
          state_nxt = S_L1;
      end
      S_L1:
      begin
        if (ack && t1_in == L1_INVALID)
        begin
          fin       = 1'b1;
          fin_abort = 1'b1;
          fin_code  = FC_TRANS_SEC;                                    // see [RULE1]
          state_nxt = S_IDLE;
        end
        else if (ack && t1_in == L1_SECTION)
          state_nxt = S_CHK;
        else if (ack)
          state_nxt = S_L2;                                            // see [RULE6] [RULE7]
      end
      S_L2:
      begin
        if (ack)
          state_nxt = S_CHK;
      end
      default:
      begin
        // Translation, then domain, then permission
        fin       = 1'b1;
        fin_dom   = dom;
        state_nxt = S_IDLE;
        if (page_bad)
        begin
          fin_abort = 1'b1;
          fin_code  = FC_TRANS_PAGE;                                   // see [RULE21]
        end
        else if (dacc == DA_NONE || dacc == DA_RSVD)
        begin
          fin_abort = 1'b1;                                            // see [RULE22]
          fin_code  = is_sec ? FC_DOM_SEC : FC_DOM_PAGE;
        end
        else if (dacc == DA_CLIENT && !perm_ok)
        begin
          fin_abort = 1'b1;                                            // see [RULE23]
          fin_code  = is_sec ? FC_PERM_SEC : FC_PERM_PAGE;
        end
        else
          fin_fill = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Walk state and request acceptance
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state_r   <= S_IDLE;
      REQ_READY <= 1'b1;
    end
    else
    begin
      state_r   <= state_nxt;
      REQ_READY <= (state_nxt == S_IDLE);
    end
  end

  // Captured request
  always_ff @(posedge MCLK)
  begin
    if (RST)
      req_r <= '0;
    else if (take)
      req_r <= REQ;
  end

  // Captured descriptors
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      desc1_r <= '0;
      desc2_r <= '0;
    end
    else if (ack && state_r == S_L1)
      desc1_r <= MEM_RD_DATA;
    else if (ack && state_r == S_L2)
      desc2_r <= MEM_RD_DATA;
  end

  // Table memory reads, held until answered
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      MEM_RD_REQ  <= 1'b0;
      MEM_RD_ADDR <= '0;
    end
    else if (state_r == S_IDLE && state_nxt == S_L1)
    begin
      MEM_RD_REQ  <= 1'b1;
      MEM_RD_ADDR <= l1_addr;
    end
    else if (state_r == S_L1 && state_nxt == S_L2)
    begin
      MEM_RD_REQ  <= 1'b1;
      MEM_RD_ADDR <= l2_addr;
    end
    else if (ack)
      MEM_RD_REQ  <= 1'b0;
  end

  // Response; address only after all checks pass
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      RESP_VALID <= 1'b0;
      RESP_ABORT <= 1'b0;
      RESP_PA    <= '0;
      RESP_CLASS <= CL_NCNB;
      EXT_GO     <= 1'b0;
    end
    else
    begin
      RESP_VALID <= fin;
      EXT_GO     <= fin && !fin_abort;                                 // see [RULE18]
      if (fin)
      begin
        RESP_ABORT <= fin_abort;                                       // see [RULE18]
        RESP_PA    <= fin_abort ? '0 : fin_pa;                         // see [RULE15]
        RESP_CLASS <= fin_abort ? CL_NCNB : fin_cls;
      end
    end
  end

  // Fault status and address records
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      DATA_FAULT_STATUS <= '0;
      PREF_FAULT_STATUS <= '0;
      FAULT_ADDRESS     <= '0;
    end
    else if (fin && fin_abort && fin_instr)
      PREF_FAULT_STATUS <= '{domain: fin_dom, fault_code_field: fin_code}; // see [RULE19]
    else if (fin && fin_abort)
    begin
      DATA_FAULT_STATUS <= '{domain: fin_dom, fault_code_field: fin_code}; // see [RULE19]
      FAULT_ADDRESS     <= fin_va;                                     // see [RULE20]
    end
  end

  // TLB fill with whole page or accessed quarter
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      TLB_WR   <= 1'b0;
      TLB_FILL <= '0;
    end
    else
    begin
      TLB_WR <= fin && fin_fill;
      if (fin && fin_fill)
        TLB_FILL <= '{va_base: req_r.va & ~low_mask(size_lsb(map_size)), // see [RULE13]
                      pa_base: fin_pa & ~low_mask(size_lsb(map_size)),
                      size:    map_size,
                      perm:    perm_sel,
                      domain:  dom,
                      cls:     fin_cls};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_align;
    @(posedge MCLK) disable iff (RST)
    take && align_bad |=> RESP_VALID && RESP_ABORT && !EXT_GO &&
                          DATA_FAULT_STATUS.fault_code_field == FC_ALIGN;
  endproperty
  a_align: assert property (p_align) else $error("alignment fault not reported"); // see [RULE16]

  property p_flat;
    @(posedge MCLK) disable iff (RST)
    take && !align_bad && !CTRL_MMU_EN |=> RESP_VALID && !RESP_ABORT &&
                                           RESP_PA == $past(REQ.va);
  endproperty
  a_flat: assert property (p_flat) else $error("flat access faulted"); // see [RULE17]

  property p_l1_invalid;
    @(posedge MCLK) disable iff (RST)
    state_r == S_L1 && ack && t1_in == L1_INVALID && !req_r.instr |=>
      RESP_ABORT && DATA_FAULT_STATUS.fault_code_field == FC_TRANS_SEC;
  endproperty
  a_l1_invalid: assert property (p_l1_invalid) else $error("bad section fault"); // see [RULE1]

  property p_coarse;
    @(posedge MCLK) disable iff (RST)
    state_r == S_L1 && ack && t1_in == L1_COARSE |=> MEM_RD_REQ &&
      MEM_RD_ADDR == {$past(MEM_RD_DATA[31:10]), req_r.va[19:12], 2'h0};
  endproperty
  a_coarse: assert property (p_coarse) else $error("bad coarse fetch"); // see [RULE6]

  property p_fine;
    @(posedge MCLK) disable iff (RST)
    state_r == S_L1 && ack && t1_in == L1_FINE |=> MEM_RD_REQ &&
      MEM_RD_ADDR == {$past(MEM_RD_DATA[31:12]), req_r.va[19:10], 2'h0};
  endproperty
  a_fine: assert property (p_fine) else $error("bad fine fetch"); // see [RULE7]

  property p_suppress;
    @(posedge MCLK) disable iff (RST)
    RESP_VALID |-> EXT_GO == !RESP_ABORT && (RESP_ABORT -> !TLB_WR && RESP_PA == '0);
  endproperty
  a_suppress: assert property (p_suppress) else $error("faulted access went out"); // see [RULE18]

  property p_pref_far;
    @(posedge MCLK) disable iff (RST)
    RESP_VALID && RESP_ABORT && req_r.instr |-> $stable(FAULT_ADDRESS) &&
                                                $stable(DATA_FAULT_STATUS);
  endproperty
  a_pref_far: assert property (p_pref_far) else $error("prefetch touched data record"); // see [RULE20]

  property p_section_pa;
    @(posedge MCLK) disable iff (RST)
    TLB_WR && TLB_FILL.size == SZ_1M |-> RESP_PA[31:20] == desc1_r[31:20] &&
                                         RESP_PA[19:0] == req_r.va[19:0];
  endproperty
  a_section_pa: assert property (p_section_pa) else $error("bad section address"); // see [RULE5]

endmodule // mtw_walker

// *** verilog/mtw_pkg.sv ***
// Shared constants, codes and carriers of the table walker
package mtw_pkg;

  // Address and descriptor field positions
  localparam int unsigned AMSB          = 31;
  localparam int unsigned TYPE_MSB      = 1;
  localparam int unsigned CB_LSB        = 2;
  localparam int unsigned DOM_LSB       = 5;
  localparam int unsigned DOM_W         = 4;
  localparam int unsigned SEC_PERM_LSB  = 10;
  localparam int unsigned PERM0_LSB     = 4;
  localparam int unsigned PERM_ALL_W    = 8;
  localparam int unsigned SEC_BASE_LSB  = 20;
  localparam int unsigned COARSE_LSB    = 10;
  localparam int unsigned FINE_LSB      = 12;
  localparam int unsigned COARSE_IDX    = 12;
  localparam int unsigned FINE_IDX      = 10;
  localparam int unsigned LARGE_LSB     = 16;
  localparam int unsigned QLARGE_LSB    = 14;
  localparam int unsigned SMALL_LSB     = 12;
  localparam int unsigned TINY_LSB      = 10;
  localparam logic [1:0]  WORD_OFS      = 2'h0;

  // Descriptor type codes
  localparam logic [1:0] L1_INVALID = 2'h0;
  localparam logic [1:0] L1_COARSE  = 2'h1;
  localparam logic [1:0] L1_SECTION = 2'h2;
  localparam logic [1:0] L1_FINE    = 2'h3;
  localparam logic [1:0] L2_INVALID = 2'h0;
  localparam logic [1:0] L2_LARGE   = 2'h1;
  localparam logic [1:0] L2_SMALL   = 2'h2;
  localparam logic [1:0] L2_TINY    = 2'h3;

  // Domain field and access permission field codes
  localparam logic [1:0] DA_NONE   = 2'h0;
  localparam logic [1:0] DA_CLIENT = 2'h1;
  localparam logic [1:0] DA_RSVD   = 2'h2;
  localparam logic [1:0] PERM_SYS  = 2'h0;
  localparam logic [1:0] PERM_PRIV = 2'h1;
  localparam logic [1:0] PERM_UREAD = 2'h2;

  // Fault codes, highest priority first
  localparam logic [3:0] FC_ALIGN      = 4'h1;
  localparam logic [3:0] FC_TRANS_SEC  = 4'h5;
  localparam logic [3:0] FC_TRANS_PAGE = 4'h7;
  localparam logic [3:0] FC_DOM_SEC    = 4'h9;
  localparam logic [3:0] FC_DOM_PAGE   = 4'hb;
  localparam logic [3:0] FC_PERM_SEC   = 4'hd;
  localparam logic [3:0] FC_PERM_PAGE  = 4'hf;
  localparam logic [3:0] DOM_INVALID   = 4'h0;

  typedef enum logic [1:0] {S_IDLE = 2'h0, S_L1 = 2'h1, S_L2 = 2'h2, S_CHK = 2'h3} mtw_state_t;
  typedef enum logic [2:0] {SZ_1M = 3'h0, SZ_64K = 3'h1, SZ_16K = 3'h2, SZ_4K = 3'h3,
                            SZ_1K = 3'h4} mtw_size_t;
  typedef enum logic [1:0] {CL_NCNB = 2'h0, CL_NCB = 2'h1, CL_WT = 2'h2, CL_WB = 2'h3}
    mtw_class_t;
  typedef enum logic [1:0] {AS_BYTE = 2'h0, AS_HALF = 2'h1, AS_WORD = 2'h2} mtw_asz_t;

  // Core access request
  typedef struct packed {
    logic [31:0] va;
    mtw_asz_t    asz;
    logic        write;
    logic        priv;
    logic        instr;
  } mtw_req_t;

  // Fault status record
  typedef struct packed {
    logic [3:0] domain;
    logic [3:0] fault_code_field;
  } mtw_fstat_t;

  // TLB fill entry
  typedef struct packed {
    logic [31:0] va_base;
    logic [31:0] pa_base;
    mtw_size_t   size;
    logic [1:0]  perm;
    logic [3:0]  domain;
    mtw_class_t  cls;
  } mtw_tlb_t;

endpackage

// *** verilog/mtw_perm_check.sv ***
// Access permission field check against mode, S and R bits
module mtw_perm_check
  import mtw_pkg::*;
(
  // Selected field and control bits
  input  wire logic [1:0] perm,
  input  wire logic       sys_s,
  input  wire logic       rom_r,
  // Access kind
  input  wire logic       priv,
  input  wire logic       write,
  // Verdict
  output logic            ok
);

  // Field 00 leans on S and R; S and R both set is reserved and denied
  always_comb
  begin
    case (perm)
      PERM_SYS:   ok = !write && ((sys_s && !rom_r && priv) || (!sys_s && rom_r));
      PERM_PRIV:  ok = priv;
      PERM_UREAD: ok = priv || !write;
      default:    ok = 1'b1;
    endcase
  end

endmodule // mtw_perm_check

// *** bench/mtw_mem_model.sv ***
// Behavioural table memory that answers the walker's fetches
module mtw_mem_model
(
  // Clock
  input  wire logic        clk,
  // Read port
  input  wire logic        rd_req,
  input  wire logic [31:0] rd_addr,
  output logic             rd_ack,
  output logic [31:0]      rd_data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [31:0] mem [logic [31:0]];
  int          lat = 0;

  // One ack pulse per request, data scrambled outside the ack cycle
  initial
  begin
    rd_ack  = 1'b0;
    rd_data = 32'h0;
    forever
    begin
      @(posedge clk);
      if (rd_req === 1'b1)
      begin
        repeat (lat) @(posedge clk);
        #1 rd_ack = 1'b1;
        rd_data = mem.exists(rd_addr) ? mem[rd_addr] : 32'h0;
        @(posedge clk);
        #1 rd_ack = 1'b0;
        rd_data = ~rd_data;
      end
    end
  end
endmodule // mtw_mem_model

// *** bench/tb_top.sv ***
// Self-checking bench of the table walker and fault unit
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mtw_pkg::*;

  localparam logic [17:0] TBL_BASE = 18'h00c01;
  localparam logic [31:0] DOM_CTL  = 32'h0000_02c4;  // d1 client, d3 manager, d4 reserved
  localparam logic [31:0] PV       = 32'h4567_3210;

  logic        mclk, rst, mmu_en, align_en, req_valid, req_ready, resp_valid, resp_abort;
  logic        ext_go, rd_req, rd_ack, tlb_wr, c_go, c_wr, ctrl_s, ctrl_r, priv;
  logic [31:0] resp_pa, rd_addr, rd_data, fault_addr, va;
  mtw_req_t    req;
  mtw_class_t  resp_class;
  mtw_tlb_t    tlb_fill, c_fill;
  mtw_fstat_t  dfs, pfs;
  int          errors, samples_checked, cycles, k;

  mtw_walker dut (
    .MCLK(mclk), .RST(rst), .CTRL_MMU_EN(mmu_en), .CTRL_ALIGN_EN(align_en),
    .CTRL_S(ctrl_s), .CTRL_R(ctrl_r), .TTB_BASE(TBL_BASE), .DOMAIN_ACCESS(DOM_CTL),
    .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready), .RESP_VALID(resp_valid),
    .RESP_ABORT(resp_abort), .RESP_PA(resp_pa), .RESP_CLASS(resp_class), .EXT_GO(ext_go),
    .MEM_RD_REQ(rd_req), .MEM_RD_ADDR(rd_addr), .MEM_RD_ACK(rd_ack), .MEM_RD_DATA(rd_data),
    .TLB_WR(tlb_wr), .TLB_FILL(tlb_fill), .DATA_FAULT_STATUS(dfs),
    .PREF_FAULT_STATUS(pfs), .FAULT_ADDRESS(fault_addr));

  mtw_mem_model mem_i (.clk(mclk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
                       .rd_data(rd_data));

  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      end_sim();
    end
  end

  function automatic logic [31:0] l1a(input logic [31:0] v);
    return {TBL_BASE, v[31:20], 2'h0};
  endfunction

  function automatic logic [31:0] l2a(input logic [31:0] d, input logic [31:0] v);
    return d[1:0] == 2'h1 ? {d[31:10], v[19:12], 2'h0} : {d[31:12], v[19:10], 2'h0};
  endfunction

  function automatic logic [31:0] sec(input logic [11:0] hi, input logic [1:0] perm,
                                      input logic [3:0] dom, input logic [1:0] cb);
    return {hi, 8'h0, perm, 1'b0, dom, 1'b1, cb, 2'h2};
  endfunction

  // Boundary of a filled TLB entry of a page mapping
  function automatic int fill_lsb(input mtw_size_t sz);
    return sz == SZ_64K ? 16 : sz == SZ_16K ? 14 : sz == SZ_4K ? 12 : 10;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One request, held until taken, then wait for the answer
  task automatic go(input logic [31:0] v, input mtw_asz_t asz, input logic wr, input logic in);
    int n;
    req_valid = 1'b1;
    req = '{v, asz, wr, priv, in};
    do @(posedge mclk); while (req_ready !== 1'b1);
    #1 req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      #1 n++;
    end
    check(n < 40, 1'b1);
    c_go = ext_go;
    c_wr = tlb_wr;
    c_fill = tlb_fill;
    @(posedge mclk);
    #1;
  endtask

  task automatic expect_resp(input logic ab, input logic [31:0] pa, input mtw_class_t cl);
    check(resp_abort, ab);
    check(resp_pa, pa);
    check(resp_class, cl);
    check(c_go, !ab);
  endtask

  task automatic fault_case(input logic [31:0] v, input logic [31:0] l1, input logic [31:0] l2,
                            input logic [3:0] code, input logic [3:0] dom);
    mem_i.mem[l1a(v)] = l1;
    mem_i.mem[l2a(l1, v)] = l2;
    go(v, AS_WORD, 1'b0, 1'b0);
    check(resp_abort, code != 4'h0);
    if (code != 4'h0)
    begin
      check(c_go, 1'b0);
      check(resp_pa, 32'h0);
      check(dfs, {dom, code});
      check(fault_addr, v);
    end
    else
      check(c_go, 1'b1);
  endtask

  task automatic page_case(input logic [31:0] l1, input logic [31:0] l2, input int rep,
                           input int lsb, input mtw_size_t sz);
    logic [31:0] a;
    logic [31:0] m;
    logic [31:0] e;
    mem_i.mem[l1a(PV)] = l1;
    a = l2a(l1, PV) & ~((rep << 2) - 1);
    for (int i = 0; i < rep; i++) mem_i.mem[a + 4 * i] = l2;
    go(PV, AS_WORD, 1'b1, 1'b0);
    m = (32'h1 << lsb) - 1;
    e = (l2 & ~m) | (PV & m);
    expect_resp(1'b0, e, CL_WB);
    check(c_wr, 1'b1);
    check(c_fill.size, sz);
    m = (32'h1 << fill_lsb(sz)) - 1;
    check(c_fill.va_base, PV & ~m);
    check(c_fill.pa_base, e & ~m);
  endtask

  task automatic end_sim;
    $display("Counts: %0d checks, %0d errors", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {rst, mmu_en, align_en, req_valid} = 4'h8;
    {ctrl_s, ctrl_r, priv} = 3'h0;
    req = '0;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    void'($urandom(13));
    for (int i = 0; i < 4; i++)
    begin
      va = $urandom & 32'hffff_fffc;
      go(va, AS_WORD, 1'b1, 1'b0);
      expect_resp(1'b0, va, CL_NCNB);
    end
    $display("test flat done");
    align_en = 1'b1;
    va = $urandom | 32'h1;
    go(va, AS_HALF, 1'b1, 1'b0);
    expect_resp(1'b1, 32'h0, CL_NCNB);
    check(dfs, {DOM_INVALID, FC_ALIGN});
    check(fault_addr, va);
    go(va, AS_BYTE, 1'b0, 1'b0);
    expect_resp(1'b0, va, CL_NCNB);
    $display("test align done");
    mmu_en = 1'b1;
    fault_case(PV | 32'h2, 32'h0, 32'h0, FC_ALIGN, DOM_INVALID);
    align_en = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      va = $urandom & 32'hffff_fffc;
      k = $urandom;
      mem_i.lat = k[6:5];
      mem_i.mem[l1a(va)] = sec(k[31:20], 2'h3, 4'h1, k[1:0]);
      go(va, AS_WORD, k[4], 1'b0);
      expect_resp(1'b0, {k[31:20], va[19:0]}, mtw_class_t'(k[1:0]));
      check(c_fill.domain, 4'h1);
      check(c_fill.perm, 2'h3);
    end
    $display("test section done");
    fault_case(PV, 32'h0, 32'h0, FC_TRANS_SEC, 4'h0);
    fault_case(PV, sec(12'h812, 2'h1, 4'h2, 2'h0), 32'h0, FC_DOM_SEC, 4'h2);
    fault_case(PV, sec(12'h812, 2'h1, 4'h4, 2'h0), 32'h0, FC_DOM_SEC, 4'h4);
    fault_case(PV, sec(12'h812, 2'h1, 4'h1, 2'h0), 32'h0, FC_PERM_SEC, 4'h1);
    fault_case(PV, sec(12'h812, 2'h1, 4'h3, 2'h0), 32'h0, 4'h0, 4'h0);
    fault_case(PV, 32'h0020_0031, 32'h0, FC_TRANS_PAGE, 4'h1);
    fault_case(PV, 32'h0020_0031, 32'habcd_e43f, FC_TRANS_PAGE, 4'h1);
    fault_case(PV, 32'h0020_0051, 32'h1234_555e, FC_DOM_PAGE, 4'h2);
    fault_case(PV, 32'h0020_0031, 32'h1234_555e, FC_PERM_PAGE, 4'h1);
    // Supervisor accesses under the S and R interpretation bits
    priv = 1'b1;
    ctrl_s = 1'b1;
    fault_case(PV, sec(12'h812, 2'h0, 4'h1, 2'h0), 32'h0, 4'h0, 4'h0);
    {ctrl_s, ctrl_r} = 2'h1;
    fault_case(PV, sec(12'h812, 2'h0, 4'h1, 2'h0), 32'h0, 4'h0, 4'h0);
    ctrl_r = 1'b0;
    fault_case(PV, sec(12'h812, 2'h0, 4'h1, 2'h0), 32'h0, FC_PERM_SEC, 4'h1);
    fault_case(PV, sec(12'h812, 2'h1, 4'h1, 2'h0), 32'h0, 4'h0, 4'h0);
    priv = 1'b0;
    va = fault_addr;
    mem_i.mem[l1a(PV)] = 32'h0;
    go(PV, AS_WORD, 1'b0, 1'b1);
    check(pfs, {4'h0, FC_TRANS_SEC});
    check(fault_addr, va);
    $display("test fault done");
    page_case(32'h0020_0031, 32'h1234_5ffe, 1, 12, SZ_4K);
    page_case(32'h0020_0031, 32'h1234_57fe, 1, 12, SZ_1K);
    page_case(32'h0020_0031, 32'h5678_0ffd, 16, 16, SZ_64K);
    page_case(32'h0020_0031, 32'h5678_07fd, 16, 16, SZ_16K);
    page_case(32'h0030_0033, 32'habcd_e43f, 1, 10, SZ_1K);
    page_case(32'h0030_0033, 32'h1234_5ffe, 4, 12, SZ_4K);
    page_case(32'h0030_0033, 32'h5678_0ffd, 64, 16, SZ_64K);
    $display("test page done");
    end_sim();
  end
endmodule // tb_top
